// [hw/cgm_device.sv]
`include "cgm_params.svh"
`default_nettype none
module cgm_device #(
  parameter int BLINK_CYCLES = `CGM_BLINK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Link to host
  cgm_link_if.dev link,
  // Display scan
  input wire logic [6:0] scan_addr_in,
  input wire logic [2:0] scan_row_in,
  input wire logic [5:0] icon_word_in,
  output logic [4:0] glyph_row_out,
  output logic [4:0] icon_bits_out,
  output logic blink_phase_out,
  output logic [1:0] cg_memory_config_out
);
  cgm_pkg::cgm_parse_t parse_r;
  logic [1:0] register_page_select_r;
  logic [2:0] memory_bank_select_r;
  logic [6:0] addr_r;
  logic [1:0] cfg_r;
  logic blink_en_r;
  logic phase_r;
  logic [31:0] blink_cnt_r;
  logic [7:0] b;
  logic payload;
  logic is_ram;
  logic is_cmd;
  logic cmd_addr;
  logic cmd_bank;
  logic cmd_cfg;
  logic cmd_blink;
  logic cmd_read;
  logic [7:0] read_val;
  logic [7:0] scan_code;
  logic [3:0] scan_col;
  logic use_user;
  logic [4:0] user_row;
  logic [4:0] rom_row;
  logic [6:0] icon_idx;

  // No reset: contents are undefined after power-on until reloaded
  logic [7:0] display_text_ram [0:127];
  logic [4:0] user_pattern_ram [0:2][0:127];
  logic [4:0] icon_ram [0:79];

  assign b = link.xfer_byte;
  assign payload = link.xfer_valid && !link.xfer_stop &&
                   (parse_r != cgm_pkg::CGM_ST_CTRL);
  assign is_ram = payload && (register_page_select_r == `CGM_PAGE_RAM);
  assign is_cmd = payload && (register_page_select_r == `CGM_PAGE_CMD);
  assign cmd_addr = is_cmd && b[`CGM_OP_ADDR_BIT];
  assign cmd_bank = is_cmd && (b[7:3] == `CGM_OP_BANK);
  assign cmd_cfg = is_cmd && (b[7:2] == `CGM_OP_CFG);
  assign cmd_blink = is_cmd && (b[7:1] == `CGM_OP_BLINK);
  assign cmd_read = is_cmd && (b == `CGM_OP_READ);

  // Control byte parsing
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      parse_r <= cgm_pkg::CGM_ST_CTRL;
    end else if (link.xfer_stop) begin
      parse_r <= cgm_pkg::CGM_ST_CTRL;
    end else if (link.xfer_valid) begin
      unique case (parse_r)
        cgm_pkg::CGM_ST_CTRL: begin
          parse_r <= b[`CGM_CTRL_MORE_BIT] ? cgm_pkg::CGM_ST_ONE
                                           : cgm_pkg::CGM_ST_RUN; // [RULE11]
        end
        cgm_pkg::CGM_ST_ONE: begin
          parse_r <= cgm_pkg::CGM_ST_CTRL;
        end
        cgm_pkg::CGM_ST_RUN: begin
          parse_r <= cgm_pkg::CGM_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      register_page_select_r <= `CGM_PAGE_CMD;
    end else if (link.xfer_valid && !link.xfer_stop &&
                 parse_r == cgm_pkg::CGM_ST_CTRL) begin
      register_page_select_r <=
        b[`CGM_CTRL_PAGE_HI:`CGM_CTRL_PAGE_LO]; // [RULE11]
    end
  end

  // Bank, address counter, configuration
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      memory_bank_select_r <= `CGM_BANK_TEXT;
    end else if (cmd_bank) begin
      memory_bank_select_r <= b[2:0]; // [RULE6] [RULE8]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      addr_r <= 7'h00;
    end else if (cmd_addr) begin
      addr_r <= b[6:0]; // [RULE6]
    end else if (is_ram || cmd_read) begin
      addr_r <= addr_r + 7'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      cfg_r <= `CGM_CFG_RESET;
      blink_en_r <= 1'b0;
    end else begin
      if (cmd_cfg) begin
        cfg_r <= b[1:0];
      end
      if (cmd_blink) begin
        blink_en_r <= b[0];
      end
    end
  end

  // RAM writes
  always_ff @(posedge mclk_in) begin
    if (is_ram) begin
      if (memory_bank_select_r == `CGM_BANK_TEXT) begin
        display_text_ram[addr_r] <= b; // [RULE2]
      end else if (memory_bank_select_r <= `CGM_BANK_USER2) begin
        user_pattern_ram[2'(memory_bank_select_r - `CGM_BANK_USER0)][addr_r]
          <= b[4:0]; // [RULE3] [RULE6]
      end else if (memory_bank_select_r == `CGM_BANK_ICON &&
                   addr_r <= `CGM_ICON_ODD_LAST) begin
        icon_ram[addr_r] <= b[4:0]; // [RULE8] [RULE9]
      end
    end
  end

  // Read data path
  always_comb begin
    read_val = 8'h00;
    if (memory_bank_select_r == `CGM_BANK_TEXT) begin
      read_val = display_text_ram[addr_r];
    end else if (memory_bank_select_r <= `CGM_BANK_USER2) begin
      read_val = {3'h0, user_pattern_ram[
        2'(memory_bank_select_r - `CGM_BANK_USER0)][addr_r]}; // [RULE6]
    end else if (memory_bank_select_r == `CGM_BANK_ICON &&
                 addr_r <= `CGM_ICON_ODD_LAST) begin
      read_val = {3'h0, icon_ram[addr_r]}; // [RULE9]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      link.rsp_valid <= 1'b0;
      link.rsp_byte <= 8'h00;
    end else begin
      link.rsp_valid <= cmd_read;
      if (cmd_read) begin
        link.rsp_byte <= read_val;
      end
    end
  end

  // Blink phase divider
  always_ff @(posedge mclk_in) begin
    if (!rstn_in || !blink_en_r) begin
      blink_cnt_r <= 32'h0;
      phase_r <= 1'b0; // [RULE12]
    end else if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_r <= 32'h0;
      phase_r <= !phase_r; // [RULE12]
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // Glyph lookup
  assign scan_code = display_text_ram[scan_addr_in];
  assign scan_col = scan_code[7:4]; // [RULE2]

  always_comb begin
    unique case (scan_col)
      4'h0: use_user = 1'b1; // [RULE4]
      4'h1: use_user = (cfg_r == `CGM_CFG_COL01) ||
                       (cfg_r == `CGM_CFG_ALL); // [RULE3] [RULE4] [RULE5]
      4'h2: use_user = (cfg_r == `CGM_CFG_COL02) ||
                       (cfg_r == `CGM_CFG_ALL); // [RULE3] [RULE4] [RULE5]
      default: use_user = 1'b0;
    endcase
  end

  assign user_row =
    user_pattern_ram[scan_col[1:0]][{scan_code[3:0], scan_row_in}]; // [RULE2]

  cgm_pattern_rom u_rom (
    .code_in(scan_code),
    .row_in(scan_row_in),
    .row_bits_out(rom_row)
  );

  assign icon_idx = {1'b0, icon_word_in} +
    (phase_r ? `CGM_ICON_ODD_FIRST : `CGM_ICON_EVEN_FIRST); // [RULE10]

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      glyph_row_out <= 5'h00;
      icon_bits_out <= 5'h00;
      blink_phase_out <= 1'b0;
      cg_memory_config_out <= `CGM_CFG_RESET;
    end else begin
      glyph_row_out <= use_user ? user_row : rom_row; // [RULE3]
      if ({1'b0, icon_word_in} <= `CGM_ICON_EVEN_LAST) begin
        icon_bits_out <= icon_ram[icon_idx]; // [RULE10] [RULE12]
      end else begin
        icon_bits_out <= 5'h00;
      end
      blink_phase_out <= phase_r;
      cg_memory_config_out <= cfg_r;
    end
  end
endmodule
`default_nettype wire

// [hw/cgm_params.svh]
// Behaviour
// (RULE1) Fixed pattern ROM holds 240 glyphs
// (RULE2) Code upper nibble column, lower nibble row
// (RULE3) Up to 48 user glyphs overlay ROM columns
// (RULE4) Config 00 column 0; 11 columns 0-2
// (RULE5) Config 01 columns 0,2; 10 columns 0,1
// (RULE6) Host selects bank, loads address, moves data
// (RULE7) User RAM lost at power-down; host reloads
// (RULE8) Bank select 100 picks icon RAM
// (RULE9) Icon data uses bits 4 to 0
// (RULE10) Icon 00h-27h even phase, 28h-4Fh odd
// (RULE11) Control byte: bit 7 more, bits 6-5 page
// (RULE12) Blink alternates halves; otherwise even half only
`ifndef CGM_PARAMS_SVH
`define CGM_PARAMS_SVH

// Control byte fields
`define CGM_CTRL_MORE_BIT 7
`define CGM_CTRL_PAGE_HI 6
`define CGM_CTRL_PAGE_LO 5
`define CGM_PAGE_CMD 2'h0
`define CGM_PAGE_RAM 2'h1
`define CGM_CTRL_ONE_CMD 8'h80
`define CGM_CTRL_RUN_CMD 8'h00
`define CGM_CTRL_RUN_RAM 8'h20

// Command encodings on page 00
`define CGM_OP_ADDR_BIT 7
`define CGM_OP_BANK 5'h02
`define CGM_OP_CFG 6'h01
`define CGM_OP_BLINK 7'h01
`define CGM_OP_READ 8'h01

// Memory banks
`define CGM_BANK_TEXT 3'h0
`define CGM_BANK_USER0 3'h1
`define CGM_BANK_USER2 3'h3
`define CGM_BANK_ICON 3'h4

// Configuration field values and reset
`define CGM_CFG_COL0 2'h0
`define CGM_CFG_COL02 2'h1
`define CGM_CFG_COL01 2'h2
`define CGM_CFG_ALL 2'h3
`define CGM_CFG_RESET 2'h0

// Icon memory layout
`define CGM_ICON_EVEN_FIRST 7'h00
`define CGM_ICON_EVEN_LAST 7'h27
`define CGM_ICON_ODD_FIRST 7'h28
`define CGM_ICON_ODD_LAST 7'h4f

// Blink timing
`define CGM_CLK_MHZ 100
`define CGM_BLINK_MS 500
`define CGM_BLINK_CYCLES (`CGM_BLINK_MS * 1000 * `CGM_CLK_MHZ)

`endif

// [hw/cgm_pkg.sv]
`default_nettype none
package cgm_pkg;
  typedef enum logic [1:0] {
    CGM_ST_CTRL,
    CGM_ST_ONE,
    CGM_ST_RUN
  } cgm_parse_t;

  typedef enum logic [1:0] {
    CGM_OP_WRITE,
    CGM_OP_READ,
    CGM_OP_CONFIG,
    CGM_OP_BLINK
  } cgm_op_t;

  typedef enum logic [1:0] {
    CGM_H_IDLE,
    CGM_H_SEND,
    CGM_H_STOP,
    CGM_H_WAIT
  } cgm_hstate_t;
endpackage
`default_nettype wire

// [hw/cgm_link_if.sv]
`default_nettype none
interface cgm_link_if;
  logic xfer_valid;
  logic [7:0] xfer_byte;
  logic xfer_stop;
  logic rsp_valid;
  logic [7:0] rsp_byte;

  modport dev (
    input xfer_valid,
    input xfer_byte,
    input xfer_stop,
    output rsp_valid,
    output rsp_byte
  );

  modport host (
    output xfer_valid,
    output xfer_byte,
    output xfer_stop,
    input rsp_valid,
    input rsp_byte
  );
endinterface
`default_nettype wire

// [hw/cgm_pattern_rom.sv]
`default_nettype none
module cgm_pattern_rom (
  // Lookup
  input wire logic [7:0] code_in,
  input wire logic [2:0] row_in,
  // Pattern row
  output logic [4:0] row_bits_out
);
  // Column 0 holds no ROM glyph, leaving 240 patterns
  always_comb begin
    if (code_in[7:4] == 4'h0) begin // [RULE1]
      row_bits_out = 5'h00;
    end else begin
      row_bits_out = code_in[4:0] ^ {code_in[7:5], 2'h0} ^ {2'h0, row_in};
    end
  end
endmodule
`default_nettype wire

// [hw/cgm_host.sv]
`include "cgm_params.svh"
`default_nettype none
module cgm_host (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Link to device
  cgm_link_if.host link,
  // User requests
  input wire logic op_valid_in,
  input wire cgm_pkg::cgm_op_t op_kind_in,
  input wire logic [2:0] op_bank_in,
  input wire logic [6:0] op_addr_in,
  input wire logic [7:0] op_data_in,
  output logic op_ready_out,
  // Read answers and status
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic glyphs_stale_out
);
  cgm_pkg::cgm_hstate_t st_r;
  logic [7:0] seq_r [0:5];
  logic [7:0] seq_nxt [0:5];
  logic [2:0] len_r;
  logic [2:0] len_nxt;
  logic [2:0] idx_r;
  logic read_r;

  // Frame contents for each request
  always_comb begin
    seq_nxt[0] = `CGM_CTRL_ONE_CMD;
    seq_nxt[1] = {`CGM_OP_BANK, op_bank_in}; // [RULE6] [RULE8]
    seq_nxt[2] = `CGM_CTRL_ONE_CMD;
    seq_nxt[3] = {1'b1, op_addr_in}; // [RULE6]
    seq_nxt[4] = `CGM_CTRL_RUN_RAM; // [RULE11]
    seq_nxt[5] = op_data_in; // [RULE2] [RULE9]
    len_nxt = 3'h6;
    unique case (op_kind_in)
      cgm_pkg::CGM_OP_WRITE: begin
      end
      cgm_pkg::CGM_OP_READ: begin
        seq_nxt[4] = `CGM_CTRL_ONE_CMD;
        seq_nxt[5] = `CGM_OP_READ;
      end
      cgm_pkg::CGM_OP_CONFIG: begin
        seq_nxt[0] = `CGM_CTRL_RUN_CMD;
        seq_nxt[1] = {`CGM_OP_CFG, op_data_in[1:0]};
        len_nxt = 3'h2;
      end
      cgm_pkg::CGM_OP_BLINK: begin
        seq_nxt[0] = `CGM_CTRL_RUN_CMD;
        seq_nxt[1] = {`CGM_OP_BLINK, op_data_in[0]};
        len_nxt = 3'h2;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st_r <= cgm_pkg::CGM_H_IDLE;
      op_ready_out <= 1'b1;
      link.xfer_valid <= 1'b0;
      link.xfer_byte <= 8'h00;
      link.xfer_stop <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
      idx_r <= 3'h0;
      len_r <= 3'h0;
      read_r <= 1'b0;
    end else begin
      link.xfer_valid <= 1'b0;
      link.xfer_stop <= 1'b0;
      rd_valid_out <= 1'b0;
      unique case (st_r)
        cgm_pkg::CGM_H_IDLE: begin
          if (op_valid_in) begin
            for (int i = 0; i < 6; i++) begin
              seq_r[i] <= seq_nxt[i];
            end
            len_r <= len_nxt;
            read_r <= (op_kind_in == cgm_pkg::CGM_OP_READ);
            idx_r <= 3'h0;
            op_ready_out <= 1'b0;
            st_r <= cgm_pkg::CGM_H_SEND;
          end
        end
        cgm_pkg::CGM_H_SEND: begin
          link.xfer_valid <= 1'b1;
          link.xfer_byte <= seq_r[idx_r];
          idx_r <= idx_r + 3'h1;
          if (idx_r == len_r - 3'h1) begin
            st_r <= cgm_pkg::CGM_H_STOP;
          end
        end
        cgm_pkg::CGM_H_STOP: begin
          link.xfer_stop <= 1'b1;
          if (read_r) begin
            st_r <= cgm_pkg::CGM_H_WAIT;
          end else begin
            op_ready_out <= 1'b1;
            st_r <= cgm_pkg::CGM_H_IDLE;
          end
        end
        cgm_pkg::CGM_H_WAIT: begin
          if (link.rsp_valid) begin
            rd_valid_out <= 1'b1;
            rd_data_out <= link.rsp_byte;
            op_ready_out <= 1'b1;
            st_r <= cgm_pkg::CGM_H_IDLE;
          end
        end
      endcase
    end
  end

  // Set after reset until a user glyph write request is accepted in idle
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      glyphs_stale_out <= 1'b1; // [RULE7]
    end else if (st_r == cgm_pkg::CGM_H_IDLE && op_valid_in &&
                 op_kind_in == cgm_pkg::CGM_OP_WRITE &&
                 op_bank_in >= `CGM_BANK_USER0 &&
                 op_bank_in <= `CGM_BANK_USER2) begin
      glyphs_stale_out <= 1'b0; // [RULE7]
    end
  end
endmodule
`default_nettype wire

// [bench/cgm_properties.sv]
`default_nettype none
module cgm_properties (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Link signals
  input wire logic xfer_valid,
  input wire logic [7:0] xfer_byte,
  input wire logic xfer_stop,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte
);
  logic frame_start_r;

  // Marks the first byte slot of a frame
  always_ff @(posedge mclk_in) begin
    if (!rstn_in || xfer_stop) begin
      frame_start_r <= 1'b1;
    end else if (xfer_valid) begin
      frame_start_r <= 1'b0;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_point;
    xfer_valid && xfer_byte == 8'h80
    ##1 xfer_valid && xfer_byte[7:3] == 5'h02
    ##1 xfer_valid && xfer_byte == 8'h80
    ##1 xfer_valid && xfer_byte[7];
  endsequence

  sequence s_ctrl_one;
    xfer_valid && xfer_byte == 8'h80;
  endsequence

  rd_cause_a: assert property (
    rsp_valid |-> $past(xfer_valid) && $past(xfer_byte) == 8'h01)
    else $error("read answer without read command");
  rd_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("read answer longer than one cycle");
  rd_hold_a: assert property (!rsp_valid |-> $stable(rsp_byte))
    else $error("read data changed without answer");
  stop_alone_a: assert property (xfer_stop |-> !xfer_valid)
    else $error("stop together with a byte");
  frame_head_a: assert property (
    frame_start_r && xfer_valid |-> xfer_byte[4:0] == 5'h00 && !xfer_byte[6])
    else $error("frame does not open with a control byte");
  wr_order_a: assert property (
    s_point ##1 (xfer_valid && xfer_byte == 8'h20) |=> xfer_valid ##1 xfer_stop)
    else $error("write frame out of order");
  rd_order_a: assert property (
    s_point ##1 s_ctrl_one
    |=> (xfer_valid && xfer_byte == 8'h01) ##1 (rsp_valid && xfer_stop))
    else $error("read frame out of order");
  cmd_frame_a: assert property (
    frame_start_r && xfer_valid && xfer_byte == 8'h00
    |=> xfer_valid ##1 xfer_stop)
    else $error("command run frame malformed");
endmodule
`default_nettype wire

// [bench/cgm_tb.sv]
`default_nettype none
module cgm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [6:0] scan_addr_in;
  logic [2:0] scan_row_in;
  logic [5:0] icon_word_in;
  logic [4:0] glyph_row_out;
  logic [4:0] icon_bits_out;
  logic blink_phase_out;
  logic [1:0] cg_memory_config_out;
  logic op_valid_in;
  cgm_pkg::cgm_op_t op_kind_in;
  logic [2:0] op_bank_in;
  logic [6:0] op_addr_in;
  logic [7:0] op_data_in;
  logic op_ready_out;
  logic rd_valid_out;
  logic [7:0] rd_data_out;
  logic glyphs_stale_out;
  logic [7:0] exp;
  int miscompares = 0;
  int checks_done = 0;
  int n;

  always #5 mclk_in = ~mclk_in;

  cgm_link_if link ();
  cgm_device #(.BLINK_CYCLES(8)) i_cgm_device (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .link(link), .scan_addr_in(scan_addr_in),
    .scan_row_in(scan_row_in), .icon_word_in(icon_word_in),
    .glyph_row_out(glyph_row_out), .icon_bits_out(icon_bits_out),
    .blink_phase_out(blink_phase_out),
    .cg_memory_config_out(cg_memory_config_out));
  cgm_host i_cgm_host (.mclk_in(mclk_in), .rstn_in(rstn_in), .link(link),
    .op_valid_in(op_valid_in), .op_kind_in(op_kind_in),
    .op_bank_in(op_bank_in), .op_addr_in(op_addr_in),
    .op_data_in(op_data_in), .op_ready_out(op_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .glyphs_stale_out(glyphs_stale_out));
  cgm_properties i_cgm_properties (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .xfer_valid(link.xfer_valid), .xfer_byte(link.xfer_byte),
    .xfer_stop(link.xfer_stop), .rsp_valid(link.rsp_valid),
    .rsp_byte(link.rsp_byte));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] got);
    checks_done++;
    if (got !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wait_ready();
    int w;
    w = 0;
    while (op_ready_out !== 1'b1) begin
      if (w == 50) begin
        chk("op_ready_out", 8'h01, {7'h00, op_ready_out});
        end_of_test();
      end
      @(negedge mclk_in);
      w++;
    end
  endtask

  task automatic settle();
    wait_ready();
    repeat (2) @(negedge mclk_in);
  endtask

  task automatic op(input cgm_pkg::cgm_op_t k, input logic [2:0] b,
                    input logic [6:0] a, input logic [7:0] d);
    wait_ready();
    op_valid_in = 1'b1;
    op_kind_in = k;
    op_bank_in = b;
    op_addr_in = a;
    op_data_in = d;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic rd(input logic [2:0] b, input logic [6:0] a,
                    input logic [7:0] e, input string what);
    int w;
    w = 0;
    op(cgm_pkg::CGM_OP_READ, b, a, 8'h00);
    while (rd_valid_out !== 1'b1) begin
      if (w == 20) begin
        chk("rd_valid_out", 8'h01, {7'h00, rd_valid_out});
        end_of_test();
      end
      @(negedge mclk_in);
      w++;
    end
    chk(what, e, rd_data_out);
  endtask

  task automatic scan(input logic [6:0] a, input logic [5:0] w);
    scan_addr_in = a;
    scan_row_in = 3'h2;
    icon_word_in = w;
    @(negedge mclk_in);
  endtask

  function automatic logic [4:0] rom_row(input logic [7:0] c);
    return c[4:0] ^ {c[7:5], 2'b00} ^ 5'h02;
  endfunction

  initial begin
    op_valid_in = 1'b0;
    op_kind_in = cgm_pkg::CGM_OP_WRITE;
    op_bank_in = 3'h0;
    op_addr_in = 7'h00;
    op_data_in = 8'h00;
    scan_addr_in = 7'h00;
    scan_row_in = 3'h0;
    icon_word_in = 6'h00;
    repeat (16) @(negedge mclk_in);
    rstn_in = 1'b1;
    chk("stale", 8'h01, {7'h00, glyphs_stale_out});
    chk("config", 8'h00, {6'h00, cg_memory_config_out});
    for (int b = 1; b < 4; b++) begin
      op(cgm_pkg::CGM_OP_WRITE, b[2:0], 7'h0a, 8'h10 + b[7:0]);
    end
    chk("stale", 8'h00, {7'h00, glyphs_stale_out});
    rd(3'h1, 7'h0a, 8'h11, "user");
    op(cgm_pkg::CGM_OP_WRITE, 3'h1, 7'h0b, 8'hff);
    rd(3'h1, 7'h0b, 8'h1f, "user width");
    for (int i = 0; i < 4; i++) begin
      exp = 8'h01 + 8'h10 * i[7:0];
      op(cgm_pkg::CGM_OP_WRITE, 3'h0, i[6:0], exp);
    end
    rd(3'h0, 7'h01, 8'h11, "text");
    for (int c = 0; c < 4; c++) begin
      op(cgm_pkg::CGM_OP_CONFIG, 3'h0, 7'h00, c[7:0]);
      settle();
      chk("config", c[7:0], {6'h00, cg_memory_config_out});
      for (int i = 0; i < 4; i++) begin
        scan(i[6:0], 6'h00);
        if (i == 0 || (i == 1 && c[1]) || (i == 2 && c[0])) begin
          exp = 8'h11 + i[7:0];
        end else begin
          exp = {3'h0, rom_row(8'h01 + 8'h10 * i[7:0])};
        end
        chk("glyph", exp, {3'h0, glyph_row_out});
      end
    end
    op(cgm_pkg::CGM_OP_WRITE, 3'h4, 7'h05, 8'hea);
    op(cgm_pkg::CGM_OP_WRITE, 3'h4, 7'h2d, 8'h15);
    rd(3'h4, 7'h05, 8'h0a, "icon");
    rd(3'h5, 7'h00, 8'h00, "no bank");
    scan(7'h00, 6'h05);
    chk("icon even", 8'h0a, {3'h0, icon_bits_out});
    op(cgm_pkg::CGM_OP_BLINK, 3'h0, 7'h00, 8'h01);
    n = 0;
    while (blink_phase_out !== 1'b1) begin
      if (n == 40) begin
        chk("phase", 8'h01, {7'h00, blink_phase_out});
        end_of_test();
      end
      @(negedge mclk_in);
      n++;
    end
    @(negedge mclk_in);
    chk("phase", 8'h01, {7'h00, blink_phase_out});
    chk("icon odd", 8'h15, {3'h0, icon_bits_out});
    op(cgm_pkg::CGM_OP_BLINK, 3'h0, 7'h00, 8'h00);
    settle();
    chk("phase", 8'h00, {7'h00, blink_phase_out});
    chk("icon off", 8'h0a, {3'h0, icon_bits_out});
    rstn_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rstn_in = 1'b1;
    chk("stale", 8'h01, {7'h00, glyphs_stale_out});
    chk("config", 8'h00, {6'h00, cg_memory_config_out});
    op(cgm_pkg::CGM_OP_WRITE, 3'h1, 7'h00, 8'h06);
    rd(3'h1, 7'h00, 8'h06, "reload");
    chk("stale", 8'h00, {7'h00, glyphs_stale_out});
    end_of_test();
  end
endmodule
`default_nettype wire
